/* bench/wal_master_model.sv */
// Access channel master model driving the parameter bank requests
`timescale 1ns/1ps
module wal_master_model (
  input wire logic ref_clk,
  output wal_pkg::wal_req_type req,
  input wire wal_pkg::wal_rsp_type rsp
);
  initial
  begin
    req = '0;
  end

  // ----------------------------------------
  // One request per call
  // ----------------------------------------
  // Held for one taking edge only, so it is never taken twice
  task automatic access(input logic [1:0] ch, input logic wr,
    input logic [15:0] a, input logic [15:0] d,
    output logic [15:0] rd, output logic rf, output logic ak);
    begin
      @(posedge ref_clk);
      #1;
      req.valid = 1'b1;
      req.chan = wal_pkg::wal_chan_type'(ch);
      req.write = wr;
      req.addr = a;
      req.wdata = d;
      @(posedge ref_clk);
      #1;
      rd = rsp.rdata;
      rf = rsp.refused;
      ak = rsp.ack;
      // Released address and data lines show the inverse, never a stale copy
      req.valid = 1'b0;
      req.addr = ~a;
      req.wdata = ~d;
    end
  endtask
endmodule

/* bench/warning_and_access_lock_params_test.sv */
// Self-checking bench of the warning and access lock parameter bank
`timescale 1ns/1ps
module warning_and_access_lock_params_test;
  logic ref_clk;
  logic nrst;
  logic ce;
  wal_pkg::wal_req_type req;
  wal_pkg::wal_rsp_type rsp;
  logic [15:0] warn_cause;
  logic [15:0] warn_code_in;
  logic fault_clear_command;
  logic [1:0] ctrl_mode;
  logic power_stage_enable_a;
  logic power_stage_enable_b;
  logic stop_in;
  logic signed [15:0] ain1_sample;
  logic stop_out;
  logic [15:0] warn_word;
  logic [15:0] last_warning_code;
  logic channel_lock;
  logic signed [15:0] current_setpoint;
  int bad_count;
  int num_checks;

  wal_param_bank dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .req(req),
    .rsp(rsp),
    .warn_cause(warn_cause),
    .warn_code_in(warn_code_in),
    .fault_clear_command(fault_clear_command),
    .ctrl_mode(ctrl_mode),
    .power_stage_enable_a(power_stage_enable_a),
    .power_stage_enable_b(power_stage_enable_b),
    .stop_in(stop_in),
    .ain1_sample(ain1_sample),
    .stop_out(stop_out),
    .warn_word(warn_word),
    .last_warning_code(last_warning_code),
    .channel_lock(channel_lock),
    .current_setpoint(current_setpoint)
  );

  wal_master_model mst (
    .ref_clk(ref_clk),
    .req(req),
    .rsp(rsp)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", bad_count, num_checks);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Every access is answered; a refused one returns zero data
  task automatic acc(input logic [1:0] ch, input logic wr,
    input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp,
    input logic exp_rf);
    logic [15:0] rd;
    logic rf;
    logic ak;
    mst.access(ch, wr, a, d, rd, rf, ak);
    check({15'h0000, ak}, 16'h0001);
    check({15'h0000, rf}, {15'h0000, exp_rf});
    if (!wr)
      check(rd, exp);
  endtask

  initial
  begin
    #300000;
    bad_count++;
    final_report();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    bad_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    warn_cause = 16'h0000;
    warn_code_in = 16'h0000;
    fault_clear_command = 1'b0;
    ctrl_mode = 2'h3;
    power_stage_enable_a = 1'b0;
    power_stage_enable_b = 1'b0;
    stop_in = 1'b0;
    ain1_sample = 16'sh0000;
    cyc(20);
    nrst = 1'b1;
    cyc(1);
    acc(2'h0, 1'b0, wal_pkg::ADDR_AIN1_SCALE, 16'h0000, 16'h012c, 1'b0);
    acc(2'h0, 1'b0, wal_pkg::ADDR_CHANNEL_LOCK, 16'h0000, 16'h0000, 1'b0);
    // Lock handling: only the fieldbus, only 0 or 1
    acc(2'h1, 1'b1, wal_pkg::ADDR_CHANNEL_LOCK, 16'h0001, 16'h0000, 1'b1);
    acc(2'h0, 1'b1, wal_pkg::ADDR_CHANNEL_LOCK, 16'h0002, 16'h0000, 1'b1);
    check({15'h0000, channel_lock}, 16'h0000);
    acc(2'h0, 1'b1, wal_pkg::ADDR_CHANNEL_LOCK, 16'h0001, 16'h0000, 1'b0);
    check({15'h0000, channel_lock}, 16'h0001);
    for (int c = 1; c < 4; c++)
    begin
      acc(c[1:0], 1'b0, wal_pkg::ADDR_AIN1_SCALE, 16'h0000, 16'h0000, 1'b1);
      acc(c[1:0], 1'b1, wal_pkg::ADDR_AIN1_SCALE, 16'h0064, 16'h0000, 1'b1);
    end
    acc(2'h0, 1'b0, wal_pkg::ADDR_AIN1_SCALE, 16'h0000, 16'h012c, 1'b0);
    stop_in = 1'b1;
    cyc(4);
    check({15'h0000, stop_out}, 16'h0001);
    stop_in = 1'b0;
    acc(2'h0, 1'b1, wal_pkg::ADDR_CHANNEL_LOCK, 16'h0000, 16'h0000, 1'b0);
    acc(2'h1, 1'b0, wal_pkg::ADDR_AIN1_SCALE, 16'h0000, 16'h012c, 1'b0);
    acc(2'h1, 1'b1, wal_pkg::ADDR_AIN1_SCALE, 16'h0064, 16'h0000, 1'b0);
    acc(2'h0, 1'b0, wal_pkg::ADDR_AIN1_SCALE, 16'h0000, 16'h0064, 1'b0);
    // Read-only and unmapped places
    acc(2'h0, 1'b1, wal_pkg::ADDR_AIN1_VOLTAGE, 16'h0005, 16'h0000, 1'b1);
    acc(2'h0, 1'b1, wal_pkg::ADDR_WARN_WORD, 16'hffff, 16'h0000, 1'b1);
    acc(2'h0, 1'b0, 16'h0ffe, 16'h0000, 16'h0000, 1'b1);
    // Scale range edges, and the voltage clamp
    acc(2'h0, 1'b1, wal_pkg::ADDR_AIN1_SCALE, 16'h7530, 16'h0000, 1'b0);
    acc(2'h0, 1'b1, wal_pkg::ADDR_AIN1_SCALE, 16'h7531, 16'h0000, 1'b1);
    acc(2'h0, 1'b1, wal_pkg::ADDR_AIN1_SCALE, 16'h8ad0, 16'h0000, 1'b0);
    acc(2'h0, 1'b1, wal_pkg::ADDR_AIN1_SCALE, 16'h8acf, 16'h0000, 1'b1);
    acc(2'h0, 1'b0, wal_pkg::ADDR_AIN1_SCALE, 16'h0000, 16'h8ad0, 1'b0);
    ain1_sample = 16'shec78;
    cyc(4);
    acc(2'h0, 1'b0, wal_pkg::ADDR_AIN1_VOLTAGE, 16'h0000, 16'hec78, 1'b0);
    check(current_setpoint, 16'h3a98);
    ain1_sample = 16'sh2ee0;
    cyc(4);
    acc(2'h0, 1'b0, wal_pkg::ADDR_AIN1_VOLTAGE, 16'h0000, 16'h2710, 1'b0);
    check(current_setpoint, 16'h8ad0);
    // Warning word: latched, self-clearing and reserved bits
    warn_cause = 16'hffff;
    warn_code_in = 16'h00a5;
    cyc(2);
    check(warn_word, 16'h3bf7);
    check(last_warning_code, 16'h00a5);
    warn_cause = 16'h0000;
    cyc(2);
    check(warn_word, 16'h13f7);
    acc(2'h0, 1'b0, wal_pkg::ADDR_WARN_WORD, 16'h0000, 16'h13f7, 1'b0);
    fault_clear_command = 1'b1;
    cyc(1);
    fault_clear_command = 1'b0;
    cyc(1);
    check(warn_word, 16'h0000);
    power_stage_enable_b = 1'b1;
    cyc(5);
    check(warn_word, 16'h0400);
    power_stage_enable_b = 1'b0;
    power_stage_enable_a = 1'b1;
    cyc(5);
    check(warn_word, 16'h0400);
    power_stage_enable_a = 1'b0;
    cyc(5);
    check(warn_word, 16'h0000);
    // Clock enable low freezes the stored word
    ce = 1'b0;
    warn_cause = 16'h0004;
    cyc(3);
    check(warn_word, 16'h0000);
    ce = 1'b1;
    cyc(1);
    check(warn_word, 16'h0004);
    warn_cause = 16'h0000;
    fault_clear_command = 1'b1;
    cyc(1);
    fault_clear_command = 1'b0;
    check(warn_word, 16'h0000);
    // Position warning exists only in the upper control modes
    warn_cause = 16'h2000;
    cyc(2);
    check(warn_word, 16'h2000);
    ctrl_mode = 2'h2;
    cyc(2);
    check(warn_word, 16'h2000);
    ctrl_mode = 2'h1;
    cyc(2);
    check(warn_word, 16'h0000);
    ctrl_mode = 2'h0;
    cyc(2);
    check(warn_word, 16'h0000);
    warn_cause = 16'h0000;
    cyc(2);
    final_report();
  end
endmodule

/* hdl/wal_param_bank.sv */
// Warning word, channel lock and analogue input one parameter bank
`timescale 1ns/1ps
module wal_param_bank (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire wal_pkg::wal_req_type req,
  output wal_pkg::wal_rsp_type rsp,
  input wire logic [15:0] warn_cause,
  input wire logic [15:0] warn_code_in,
  input wire logic fault_clear_command,
  input wire logic [1:0] ctrl_mode,
  input wire logic power_stage_enable_a,
  input wire logic power_stage_enable_b,
  input wire logic stop_in,
  input wire logic signed [15:0] ain1_sample,
  output logic stop_out,
  output logic [15:0] warn_word,
  output logic [15:0] last_warning_code,
  output logic channel_lock,
  output logic signed [15:0] current_setpoint
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Index 0 and 1: power stage enables, index 2: stop input
  logic [2:0] pin_meta_r;
  logic [2:0] pin_meta_nxt;
  logic [2:0] pin_sync_r;
  logic [2:0] pin_sync_nxt;
  logic stop_out_r;
  logic stop_out_nxt;

  always_comb
  begin
    pin_meta_nxt = pin_meta_r;
    pin_sync_nxt = pin_sync_r;
    stop_out_nxt = stop_out_r;
    if (ce)
    begin
      pin_meta_nxt = {stop_in, power_stage_enable_b,
                      power_stage_enable_a};
      pin_sync_nxt = pin_meta_r;
      // Stop never looks at the lock, so no channel can mask it
      stop_out_nxt = pin_sync_r[2];  // see R12
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
      stop_out_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
      stop_out_r <= stop_out_nxt;
    end
  end

  // ----------------------------------------
  // Warning word
  // ----------------------------------------
  logic [15:0] mode_mask;
  logic [15:0] cause_eff;
  logic [15:0] warn_calc;
  logic [15:0] warn_r;
  logic [15:0] warn_nxt;
  logic [15:0] last_code_r;
  logic [15:0] last_code_nxt;

  assign mode_mask = wal_pkg::MODE_WARN_MASK[ctrl_mode];  // see R9

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_warn
      logic raw;
      if (gi == wal_pkg::WB_POWER_EN)
      begin : g_pwr
        // Either enable input alone raises the bit
        assign raw = pin_sync_r[0] | pin_sync_r[1];  // see R6
      end
      else
      begin : g_cause
        // Each cause lands on its own bit position
        assign raw = warn_cause[gi];  // see R4, see R5, see R7, see R8
      end
      assign cause_eff[gi] = raw & mode_mask[gi];  // see R9
      if (wal_pkg::RESERVED_MASK[gi])
      begin : g_resv
        assign warn_calc[gi] = 1'b0;  // see R3
      end
      else if (wal_pkg::SELF_CLEAR_MASK[gi])
      begin : g_self
        // Follows the cause and drops with it
        assign warn_calc[gi] = cause_eff[gi];  // see R1
      end
      else
      begin : g_store
        // A new cause wins over a clear in the same cycle
        assign warn_calc[gi] = cause_eff[gi] |
          (warn_r[gi] & ~fault_clear_command);  // see R2
      end
    end
  endgenerate

  always_comb
  begin
    warn_nxt = ce ? warn_calc : warn_r;
    last_code_nxt = last_code_r;
    // Detail of the general warning follows its latest cause
    if (ce && cause_eff[wal_pkg::WB_GENERAL])
      last_code_nxt = warn_code_in;  // see R3
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      warn_r <= 16'h0000;
      last_code_r <= 16'h0000;
    end
    else
    begin
      warn_r <= warn_nxt;
      last_code_r <= last_code_nxt;
    end
  end

  // ----------------------------------------
  // Analogue input one
  // ----------------------------------------
  logic signed [15:0] volt_r;
  logic signed [15:0] volt_nxt;

  always_comb
  begin
    volt_nxt = volt_r;
    if (ce)
    begin
      // Clamp so a wild converter code never leaves the range
      if (ain1_sample > wal_pkg::VOLT_MAX)
        volt_nxt = wal_pkg::VOLT_MAX;  // see R13
      else if (ain1_sample < wal_pkg::VOLT_MIN)
        volt_nxt = wal_pkg::VOLT_MIN;  // see R13
      else
        volt_nxt = ain1_sample;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      volt_r <= 16'sh0000;
    else
      volt_r <= volt_nxt;
  end

  // ----------------------------------------
  // Parameter access
  // ----------------------------------------
  logic lock_r;
  logic lock_nxt;
  logic signed [15:0] scale_r;
  logic signed [15:0] scale_nxt;
  wal_pkg::wal_rsp_type rsp_r;
  wal_pkg::wal_rsp_type rsp_nxt;
  logic from_bus;
  logic blocked;

  assign from_bus = req.chan == wal_pkg::CH_FIELDBUS;
  assign blocked = lock_r && !from_bus;  // see R11

  always_comb
  begin
    lock_nxt = lock_r;
    scale_nxt = scale_r;
    rsp_nxt = rsp_r;
    if (ce)
    begin
      rsp_nxt.ack = req.valid;
      rsp_nxt.refused = 1'b0;
      rsp_nxt.rdata = 16'h0000;
      if (req.valid && blocked)
        rsp_nxt.refused = 1'b1;  // see R11
      else if (req.valid && req.write)
      begin
        case (req.addr)
          wal_pkg::ADDR_CHANNEL_LOCK:
          begin
            if (from_bus && req.wdata <= wal_pkg::LOCK_MAX)
              lock_nxt = req.wdata[0];  // see R10, see R11
            else
              rsp_nxt.refused = 1'b1;  // see R10, see R11
          end
          wal_pkg::ADDR_AIN1_SCALE:
          begin
            if ($signed(req.wdata) >= wal_pkg::SCALE_MIN &&
                $signed(req.wdata) <= wal_pkg::SCALE_MAX)
              scale_nxt = $signed(req.wdata);  // see R14
            else
              rsp_nxt.refused = 1'b1;  // see R14
          end
          // Read-only or unmapped: nothing is stored
          default: rsp_nxt.refused = 1'b1;  // see R16
        endcase
      end
      else if (req.valid)
      begin
        case (req.addr)
          wal_pkg::ADDR_CHANNEL_LOCK: rsp_nxt.rdata = {15'h0000, lock_r};
          wal_pkg::ADDR_AIN1_VOLTAGE: rsp_nxt.rdata = volt_r;  // see R13
          wal_pkg::ADDR_AIN1_SCALE: rsp_nxt.rdata = scale_r;
          wal_pkg::ADDR_WARN_WORD: rsp_nxt.rdata = warn_r;  // see R1
          wal_pkg::ADDR_LAST_WARN: rsp_nxt.rdata = last_code_r;
          default: rsp_nxt.refused = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      lock_r <= wal_pkg::LOCK_RESET;
      scale_r <= wal_pkg::SCALE_RESET;
      rsp_r <= '0;
    end
    else
    begin
      lock_r <= lock_nxt;
      scale_r <= scale_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // ----------------------------------------
  // Current setpoint
  // ----------------------------------------
  wal_setpoint_scale u_scale (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .volt(volt_r),
    .scale(scale_r),
    .setpoint(current_setpoint)
  );

  assign rsp = rsp_r;
  assign stop_out = stop_out_r;
  assign warn_word = warn_r;
  assign last_warning_code = last_code_r;
  assign channel_lock = lock_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_self_clear;
    ce && !cause_eff[wal_pkg::WB_POS_INVALID]
      |=> !warn_r[wal_pkg::WB_POS_INVALID];
  endproperty
  a_self_clear: assert property (p_self_clear)  // see R1
    else $error("Position warning did not clear itself");

  property p_stored_hold;
    ce && warn_r[wal_pkg::WB_MOTOR_TEMP] && !fault_clear_command
      |=> warn_r[wal_pkg::WB_MOTOR_TEMP];
  endproperty
  a_stored_hold: assert property (p_stored_hold)  // see R2
    else $error("Stored warning dropped without fault clear");

  property p_fault_clear;
    ce && fault_clear_command && !cause_eff[wal_pkg::WB_CAN]
      |=> !warn_r[wal_pkg::WB_CAN];
  endproperty
  a_fault_clear: assert property (p_fault_clear)  // see R2
    else $error("Fault clear left a stored warning set");

  property p_reserved;
    (warn_r & wal_pkg::RESERVED_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)  // see R3
    else $error("Reserved warning bit is set");

  sequence s_enable_seen;
    ce && (power_stage_enable_a || power_stage_enable_b) ##1 ce ##1 ce;
  endsequence
  property p_power_enable;
    s_enable_seen |=> warn_r[wal_pkg::WB_POWER_EN];
  endproperty
  a_power_enable: assert property (p_power_enable)  // see R6
    else $error("Power stage enable warning missing");

  property p_lock_refuse;
    ce && req.valid && lock_r && !from_bus
      |=> rsp.ack && rsp.refused;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)  // see R11
    else $error("Blocked channel was served");

  property p_lock_only_bus;
    ce && req.valid && req.write && !from_bus
      |=> $stable(channel_lock) && ($stable(scale_r) || !$past(lock_r));
  endproperty
  a_lock_only_bus: assert property (p_lock_only_bus)  // see R11
    else $error("Other channel changed the lock");

  property p_lock_value;
    ce && req.valid && req.write && from_bus &&
      req.addr == wal_pkg::ADDR_CHANNEL_LOCK && req.wdata > 16'h0001
      |=> rsp.refused && $stable(channel_lock);
  endproperty
  a_lock_value: assert property (p_lock_value)  // see R10
    else $error("Lock took a value above one");

  sequence s_stop_seen;
    ce && stop_in ##1 ce ##1 ce;
  endsequence
  property p_stop_through;
    s_stop_seen |=> stop_out;
  endproperty
  a_stop_through: assert property (p_stop_through)  // see R12
    else $error("Stop input did not reach its output");

  property p_ro_write;
    ce && req.valid && req.write && !blocked &&
      req.addr == wal_pkg::ADDR_AIN1_VOLTAGE |=> rsp.refused;
  endproperty
  a_ro_write: assert property (p_ro_write)  // see R16
    else $error("Write to read-only voltage accepted");

  property p_volt_range;
    volt_r <= wal_pkg::VOLT_MAX && volt_r >= wal_pkg::VOLT_MIN;
  endproperty
  a_volt_range: assert property (p_volt_range)  // see R13
    else $error("Voltage value out of range");

endmodule

/* hdl/wal_pkg.sv */
// Package: constants and types of the warning and access lock bank
//
// Behaviour
// R1: Warning bits 10, 11 and 13 clear themselves; each bit reads 1 while active.
// R2: Stored warning bits stay set until a fault clear command erases them.
// R3: Bit 0 is the general warning, detailed by last code; 3, 14, 15 reserved.
// R4: Bit 1 flags amplifier over-temperature, bit 2 motor over-temperature.
// R5: Bit 7 CAN, bit 8 encoder, bit 9 RS485, bit 12 fieldbus warning.
// R6: Bit 10 is set when either power stage enable input is active.
// R7: Bit 11 is set on DC bus undervoltage or faulty mains phase.
// R8: Bit 13 stays set while position detection has no valid position yet.
// R9: The warning bit map is selected by the active control mode.
// R10: Channel lock holds 0 (others enabled) or 1 (others blocked).
// R11: Only the fieldbus sets the lock; locked, other channels are refused.
// R12: The lock never blocks hardware inputs such as the stop input.
// R13: Analogue input one voltage reads signed millivolts, -10000 to 10000.
// R14: Current scale is the current at 10 V, -30000 to 30000 on the bus.
// R15: A negative current scale inverts the sign of the current setpoint.
// R16: Writes to read-only parameters are refused and change nothing.
package wal_pkg;

  // ----------------------------------------
  // Parameter addresses
  // ----------------------------------------
  localparam logic [15:0] ADDR_CHANNEL_LOCK = 16'h013c;
  localparam logic [15:0] ADDR_AIN1_VOLTAGE = 16'h0902;
  localparam logic [15:0] ADDR_AIN1_SCALE = 16'h2006;
  localparam logic [15:0] ADDR_WARN_WORD = 16'h1c18;
  localparam logic [15:0] ADDR_LAST_WARN = 16'h1c1a;

  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [15:0] LOCK_MAX = 16'h0001;
  localparam logic signed [15:0] SCALE_RESET = 16'sh012c;
  localparam logic signed [15:0] SCALE_MAX = 16'sh7530;
  localparam logic signed [15:0] SCALE_MIN = -16'sh7530;
  localparam logic signed [15:0] VOLT_MAX = 16'sh2710;
  localparam logic signed [15:0] VOLT_MIN = -16'sh2710;
  // Millivolts at which the scale value is reached (10 V)
  localparam logic signed [31:0] VOLT_FULL_SCALE = 32'sh0000_2710;

  // ----------------------------------------
  // Warning word layout
  // ----------------------------------------
  localparam int WB_GENERAL = 0;
  localparam int WB_AMP_TEMP = 1;
  localparam int WB_MOTOR_TEMP = 2;
  localparam int WB_CAN = 7;
  localparam int WB_ENCODER = 8;
  localparam int WB_RS485 = 9;
  localparam int WB_POWER_EN = 10;
  localparam int WB_UNDERVOLT = 11;
  localparam int WB_FIELDBUS = 12;
  localparam int WB_POS_INVALID = 13;
  localparam logic [15:0] SELF_CLEAR_MASK = 16'h2c00;
  localparam logic [15:0] RESERVED_MASK = 16'hc008;
  // Bits that are meaningful in each control mode
  localparam logic [3:0][15:0] MODE_WARN_MASK = {
    16'h3ff7, 16'h3ff7, 16'h1ff7, 16'h1ff7};

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CH_FIELDBUS = 2'h0,
    CH_TOOL = 2'h1,
    CH_HMI = 2'h2,
    CH_FIELDBUS2 = 2'h3
  } wal_chan_type;

  typedef struct packed {
    logic valid;
    wal_chan_type chan;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wal_req_type;

  typedef struct packed {
    logic ack;
    logic refused;
    logic [15:0] rdata;
  } wal_rsp_type;

endpackage

/* hdl/wal_setpoint_scale.sv */
// Current setpoint from analogue input one and the current scale
`timescale 1ns/1ps
module wal_setpoint_scale (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic signed [15:0] volt,
  input wire logic signed [15:0] scale,
  output logic signed [15:0] setpoint
);

  logic signed [31:0] product;
  logic signed [31:0] quotient;
  logic signed [15:0] setpoint_r;
  logic signed [15:0] setpoint_nxt;

  // ----------------------------------------
  // Scaling
  // ----------------------------------------
  // Signed product keeps the sign of the scale, so a negative
  // scale inverts the setpoint; 10 V gives exactly the scale
  always_comb
  begin
    product = 32'(volt) * 32'(scale);  // see R15
    quotient = product / wal_pkg::VOLT_FULL_SCALE;  // see R14
    setpoint_nxt = ce ? quotient[15:0] : setpoint_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      setpoint_r <= 16'sh0000;
    else
      setpoint_r <= setpoint_nxt;
  end

  assign setpoint = setpoint_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_invert;
    ce && scale < 0 && volt > 16'sh0064 &&
      product <= -wal_pkg::VOLT_FULL_SCALE |=> setpoint < 0;
  endproperty
  a_invert: assert property (p_invert)  // see R15
    else $error("Negative scale did not invert the setpoint");

  property p_full_scale;
    ce && volt == wal_pkg::VOLT_MAX |=> setpoint == $past(scale);
  endproperty
  a_full_scale: assert property (p_full_scale)  // see R14
    else $error("Setpoint at 10 V differs from the scale");

endmodule
